/* cfos_regs.vh */
// Contract
// - Input select 00: two phase error bits on top, luma magnitude error below in X[5:0].
// - Input select 01: four chroma error bits in X[7:4], four luma magnitude bits in X[3:0].
// - Input select 10: three phase bits on top, chroma magnitude X[4:2], luma X[1:0].
// - Input select 11: four phase bits in X[7:4], four chroma magnitude bits in X[3:0].
// - Luma/chroma modes: 00 comb/simple, 01 simple/comb, 10 notch/simple, 11 notch/comb.
// - The chroma output select drives its own 4:1 mux with the same coding.
`ifndef CFOS_REGS_VH
`define CFOS_REGS_VH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define CFOS_ADDR_CTRL      8'h0E
`define CFOS_ADDR_STATUS    8'h10
`define CFOS_CTRL_RESET     8'h00

// ---------------------------------------------------------------
// control field positions
// ---------------------------------------------------------------
`define CFOS_TIS_HI         7
`define CFOS_TIS_LO         6
`define CFOS_TSF_HI         5
`define CFOS_TSF_LO         4
`define CFOS_LOS_HI         3
`define CFOS_LOS_LO         2
`define CFOS_COS_HI         1
`define CFOS_COS_LO         0

// ---------------------------------------------------------------
// field codes
// ---------------------------------------------------------------
`define CFOS_TIS_PH2_LUMA   2'h0
`define CFOS_TIS_CH4_LUMA4  2'h1
`define CFOS_TIS_PH3_CH_LU  2'h2
`define CFOS_TIS_PH4_CH4    2'h3
`define CFOS_OSEL_COMB      2'h0
`define CFOS_OSEL_FLAT_COMB 2'h1
`define CFOS_OSEL_FLAT      2'h2
`define CFOS_OSEL_SIMPLE    2'h3
`define CFOS_LMODE_COMB     2'h0
`define CFOS_LMODE_SIMPLE   2'h1
`define CFOS_LMODE_NOTCH    2'h2
`define CFOS_CMODE_SIMPLE   1'b0
`define CFOS_CMODE_COMB     1'b1

`endif

/* cfos_lut_pack.v */
`timescale 1ns/1ps
`include "cfos_regs.vh"

module cfos_lut_pack (
  // select
  input  wire [1:0] sel_in,
  // error terms
  input  wire [3:0] phase_err_in,
  input  wire [3:0] chroma_err_in,
  input  wire [5:0] luma_err_in,
  // packed table input
  output reg  [7:0] x_out
);

  // msbs of each error term are kept; lsbs are dropped when narrowed
  always @* begin
    case (sel_in)
      `CFOS_TIS_PH2_LUMA:  x_out = {phase_err_in[3:2], luma_err_in};
      `CFOS_TIS_CH4_LUMA4: x_out = {chroma_err_in, luma_err_in[5:2]};
      `CFOS_TIS_PH3_CH_LU: x_out = {phase_err_in[3:1], chroma_err_in[3:1],
                                    luma_err_in[5:4]};
      `CFOS_TIS_PH4_CH4:   x_out = {phase_err_in, chroma_err_in};
      default:             x_out = 8'h00;
    endcase
  end

endmodule

/* cfos_out_mux.v */
`timescale 1ns/1ps
`include "cfos_regs.vh"

module cfos_out_mux #(
  parameter W = 10
) (
  // clock and reset
  input  wire         clock_in,
  input  wire         sys_rst_in,
  // select and pixel data
  input  wire [1:0]   sel_in,
  input  wire [W-1:0] comb_in,
  input  wire [W-1:0] flat_in,
  input  wire [W-1:0] simple_in,
  // selected pixel, two cycles after the inputs
  output reg  [W-1:0] data_out
);

  reg [1:0]   sel_q;
  reg [W-1:0] comb_q;
  reg [W-1:0] flat_q;
  reg [W-1:0] simple_q;
  wire [W-1:0] flat_minus_comb;

  // one stage for every operand so the difference stays pixel aligned
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      sel_q    <= 2'h0;
      comb_q   <= {W{1'b0}};
      flat_q   <= {W{1'b0}};
      simple_q <= {W{1'b0}};
    end else begin
      sel_q    <= sel_in;
      comb_q   <= comb_in;
      flat_q   <= flat_in;
      simple_q <= simple_in;
    end
  end

  // two's complement wrap, same width as the operands
  assign flat_minus_comb = flat_q - comb_q;

  // 4:1 output selection
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      data_out <= {W{1'b0}};
    end else begin
      case (sel_q)
        `CFOS_OSEL_COMB:      data_out <= comb_q;
        `CFOS_OSEL_FLAT_COMB: data_out <= flat_minus_comb;
        `CFOS_OSEL_FLAT:      data_out <= flat_q;
        `CFOS_OSEL_SIMPLE:    data_out <= simple_q;
        default:              data_out <= comb_q;
      endcase
    end
  end

endmodule

/* cfos_top.v */
`timescale 1ns/1ps
`include "cfos_regs.vh"

module cfos_top #(
  parameter W = 10
) (
  // clock and reset
  input  wire         clock_in,
  input  wire         sys_rst_in,
  // register port
  input  wire [7:0]   reg_addr_in,
  input  wire [7:0]   reg_wdata_in,
  input  wire         reg_wr_in,
  input  wire         reg_rd_in,
  output reg  [7:0]   reg_rdata_out,
  // comb fail error terms
  input  wire         err_valid_in,
  input  wire [3:0]   phase_err_in,
  input  wire [3:0]   chroma_err_in,
  input  wire [5:0]   luma_err_in,
  // adaption table input and special function
  output reg          table_valid_out,
  output reg  [7:0]   table_x_out,
  output reg  [1:0]   luma_mode_out,
  output reg          chroma_mode_out,
  // luma pixel sources
  input  wire         pix_valid_in,
  input  wire [W-1:0] luma_comb_in,
  input  wire [W-1:0] luma_flat_in,
  input  wire [W-1:0] luma_simple_in,
  // chroma pixel sources
  input  wire [W-1:0] chroma_comb_in,
  input  wire [W-1:0] chroma_flat_in,
  input  wire [W-1:0] chroma_simple_in,
  // selected pixels
  output reg          pix_valid_out,
  output wire [W-1:0] luma_out,
  output wire [W-1:0] chroma_out
);

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  reg  [7:0] ctrl;
  wire [1:0] table_input_select;
  wire [1:0] table_special_function;
  wire [1:0] luma_output_select;
  wire [1:0] chroma_output_select;

  // full byte write; every bit is a live field, none reserved
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      ctrl <= `CFOS_CTRL_RESET;
    end else if (reg_wr_in && reg_addr_in == `CFOS_ADDR_CTRL) begin
      ctrl <= reg_wdata_in;
    end
  end

  assign table_input_select     = ctrl[`CFOS_TIS_HI:`CFOS_TIS_LO];
  assign table_special_function = ctrl[`CFOS_TSF_HI:`CFOS_TSF_LO];
  assign luma_output_select     = ctrl[`CFOS_LOS_HI:`CFOS_LOS_LO];
  assign chroma_output_select   = ctrl[`CFOS_COS_HI:`CFOS_COS_LO];

  // ---------------------------------------------------------------
  // read back
  // ---------------------------------------------------------------
  reg  [7:0] next_rdata;

  // status shows the last packed table input; unmapped reads give zero
  always @* begin
    next_rdata = 8'h00;
    if (reg_addr_in == `CFOS_ADDR_CTRL) begin
      next_rdata = ctrl;
    end else if (reg_addr_in == `CFOS_ADDR_STATUS) begin
      next_rdata = table_x_out;
    end
  end

  // data stand for the one cycle after the read strobe only
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= next_rdata;
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // adaption table input packing
  // ---------------------------------------------------------------
  wire [7:0] packed_x;
  reg  [1:0] next_luma_mode;
  reg        next_chroma_mode;

  cfos_lut_pack u_pack (
    .sel_in        (table_input_select),
    .phase_err_in  (phase_err_in),
    .chroma_err_in (chroma_err_in),
    .luma_err_in   (luma_err_in),
    .x_out         (packed_x)
  );

  // special function decode of luma and chroma treatment
  always @* begin
    case (table_special_function)
      2'h0: begin
        next_luma_mode   = `CFOS_LMODE_COMB;
        next_chroma_mode = `CFOS_CMODE_SIMPLE;
      end
      2'h1: begin
        next_luma_mode   = `CFOS_LMODE_SIMPLE;
        next_chroma_mode = `CFOS_CMODE_COMB;
      end
      2'h2: begin
        next_luma_mode   = `CFOS_LMODE_NOTCH;
        next_chroma_mode = `CFOS_CMODE_SIMPLE;
      end
      2'h3: begin
        next_luma_mode   = `CFOS_LMODE_NOTCH;
        next_chroma_mode = `CFOS_CMODE_COMB;
      end
      default: begin
        next_luma_mode   = `CFOS_LMODE_COMB;
        next_chroma_mode = `CFOS_CMODE_SIMPLE;
      end
    endcase
  end

  // table input is held between valid samples so the table sees no glitch
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      table_valid_out <= 1'b0;
      table_x_out     <= 8'h00;
      luma_mode_out   <= `CFOS_LMODE_COMB;
      chroma_mode_out <= `CFOS_CMODE_SIMPLE;
    end else begin
      table_valid_out <= err_valid_in;
      luma_mode_out   <= next_luma_mode;
      chroma_mode_out <= next_chroma_mode;
      if (err_valid_in) begin
        table_x_out <= packed_x;
      end
    end
  end

  // ---------------------------------------------------------------
  // output selection
  // ---------------------------------------------------------------
  reg pix_valid_q;

  // valid follows the two mux stages
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      pix_valid_q   <= 1'b0;
      pix_valid_out <= 1'b0;
    end else begin
      pix_valid_q   <= pix_valid_in;
      pix_valid_out <= pix_valid_q;
    end
  end

  // luma path
  cfos_out_mux #(.W(W)) u_luma_mux (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .sel_in     (luma_output_select),
    .comb_in    (luma_comb_in),
    .flat_in    (luma_flat_in),
    .simple_in  (luma_simple_in),
    .data_out   (luma_out)
  );

  // chroma path, same coding
  cfos_out_mux #(.W(W)) u_chroma_mux (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .sel_in     (chroma_output_select),
    .comb_in    (chroma_comb_in),
    .flat_in    (chroma_flat_in),
    .simple_in  (chroma_simple_in),
    .data_out   (chroma_out)
  );

endmodule

/* cfos_top_checker.sv */
`timescale 1ns/1ps
module cfos_top_checker #(
  parameter W = 10
) (
  // clock, reset, register port
  input wire         clock_in,
  input wire         sys_rst_in,
  input wire [7:0]   reg_addr_in,
  input wire [7:0]   reg_wdata_in,
  input wire         reg_wr_in,
  input wire         reg_rd_in,
  input wire [7:0]   reg_rdata_out,
  // table path
  input wire         err_valid_in,
  input wire [3:0]   phase_err_in,
  input wire [3:0]   chroma_err_in,
  input wire [5:0]   luma_err_in,
  input wire         table_valid_out,
  input wire [7:0]   table_x_out,
  input wire [1:0]   luma_mode_out,
  input wire         chroma_mode_out,
  // pixel path
  input wire         pix_valid_in,
  input wire [W-1:0] luma_comb_in,
  input wire [W-1:0] luma_flat_in,
  input wire [W-1:0] luma_simple_in,
  input wire [W-1:0] chroma_comb_in,
  input wire [W-1:0] chroma_flat_in,
  input wire [W-1:0] chroma_simple_in,
  input wire         pix_valid_out,
  input wire [W-1:0] luma_out,
  input wire [W-1:0] chroma_out
);
  reg  [7:0]   ctl;
  reg  [1:0]   live;
  // shadow of the control register; live gates checks until the pipe has refilled
  always @(posedge clock_in) begin
    ctl <= sys_rst_in ? 8'h00 : (reg_wr_in && reg_addr_in == 8'h0E) ? reg_wdata_in : ctl;
    live <= sys_rst_in ? 2'h0 : (live == 2'h2) ? live : live + 2'h1;
  end
  // expected packing, modes and mux picks from the shadow
  wire [7:0]   pk = ctl[7:6] == 2'h0 ? {phase_err_in[3:2], luma_err_in} :
                    ctl[7:6] == 2'h1 ? {chroma_err_in, luma_err_in[5:2]} :
                    ctl[7:6] == 2'h2 ? {phase_err_in[3:1], chroma_err_in[3:1], luma_err_in[5:4]} :
                    {phase_err_in, chroma_err_in};
  wire [1:0]   lm = ctl[5] ? 2'h2 : {1'b0, ctl[4]};
  wire [W-1:0] el = ctl[3:2] == 2'h0 ? luma_comb_in : ctl[3:2] == 2'h1 ?
                    luma_flat_in - luma_comb_in : ctl[3] ? (ctl[2] ? luma_simple_in : luma_flat_in)
                    : luma_comb_in;
  wire [W-1:0] ec = ctl[1:0] == 2'h0 ? chroma_comb_in : ctl[1:0] == 2'h1 ?
                    chroma_flat_in - chroma_comb_in : ctl[1] ? (ctl[0] ? chroma_simple_in :
                    chroma_flat_in) : chroma_comb_in;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  property p_pack; err_valid_in |=> table_valid_out && table_x_out == $past(pk); endproperty
  a_pack: assert property (p_pack) else $error("table input wrong");
  property p_hold; !err_valid_in |=> !table_valid_out && $stable(table_x_out); endproperty
  a_hold: assert property (p_hold) else $error("table input moved without sample");
  property p_mode;
    live == 2'h2 |-> {luma_mode_out, chroma_mode_out} == {$past(lm), $past(ctl[4])};
  endproperty
  a_mode: assert property (p_mode) else $error("special function modes wrong");
  property p_rd; reg_rd_in && reg_addr_in == 8'h0E |=> reg_rdata_out == $past(ctl); endproperty
  a_rd: assert property (p_rd) else $error("control readback wrong");
  property p_idle; !reg_rd_in |=> reg_rdata_out == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data not cleared");
  property p_pv; live == 2'h2 |-> pix_valid_out == $past(pix_valid_in, 2); endproperty
  a_pv: assert property (p_pv) else $error("pixel valid delay wrong");
  property p_luma; live == 2'h2 |-> luma_out == $past(el, 2); endproperty
  a_luma: assert property (p_luma) else $error("luma pick wrong");
  property p_chroma; live == 2'h2 |-> chroma_out == $past(ec, 2); endproperty
  a_chroma: assert property (p_chroma) else $error("chroma pick wrong");
endmodule
bind cfos_top cfos_top_checker #(.W(W)) u_chk (
  .clock_in(clock_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .err_valid_in(err_valid_in), .phase_err_in(phase_err_in),
  .chroma_err_in(chroma_err_in), .luma_err_in(luma_err_in), .table_valid_out(table_valid_out),
  .table_x_out(table_x_out), .luma_mode_out(luma_mode_out), .chroma_mode_out(chroma_mode_out),
  .pix_valid_in(pix_valid_in), .luma_comb_in(luma_comb_in), .luma_flat_in(luma_flat_in),
  .luma_simple_in(luma_simple_in), .chroma_comb_in(chroma_comb_in),
  .chroma_flat_in(chroma_flat_in), .chroma_simple_in(chroma_simple_in),
  .pix_valid_out(pix_valid_out), .luma_out(luma_out), .chroma_out(chroma_out));

/* cfos_top_tb.sv */
`timescale 1ns/1ps
module cfos_top_tb;
  reg         clock_in = 1'b0;
  reg         rst = 1'b1, wr = 1'b0, rd = 1'b0, ev = 1'b0, pv = 1'b0;
  reg  [7:0]  ad = 8'h00, wd = 8'h00, ctl;
  reg  [13:0] er = 14'h0000;
  reg  [9:0]  lc = 10'h000, lf = 10'h000, ls = 10'h000, cc = 10'h000, cf = 10'h000, cs = 10'h000;
  reg  [95:0] r;
  wire [7:0]  rdat, tx;
  wire [1:0]  lm;
  wire        tv, cm, pvo;
  wire [9:0]  lo, co;
  integer     bad_count = 0, compares = 0, cyc = 0, i;
  always #2.5 clock_in = ~clock_in;
  cfos_top #(.W(10)) dut (.clock_in(clock_in), .sys_rst_in(rst), .reg_addr_in(ad),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .err_valid_in(ev),
    .phase_err_in(er[13:10]), .chroma_err_in(er[9:6]), .luma_err_in(er[5:0]),
    .table_valid_out(tv), .table_x_out(tx), .luma_mode_out(lm), .chroma_mode_out(cm),
    .pix_valid_in(pv), .luma_comb_in(lc), .luma_flat_in(lf), .luma_simple_in(ls),
    .chroma_comb_in(cc), .chroma_flat_in(cf), .chroma_simple_in(cs), .pix_valid_out(pvo),
    .luma_out(lo), .chroma_out(co));
  // expected table input for the held error terms
  function [7:0] pack(input [1:0] s);
    case (s)
      2'h0: pack = {er[13:12], er[5:0]};
      2'h1: pack = {er[9:6], er[5:2]};
      2'h2: pack = {er[13:11], er[9:7], er[5:4]};
      default: pack = er[13:6];
    endcase
  endfunction
  // expected mux pick; difference wraps at the pixel width
  function [9:0] pick(input [1:0] s, input [9:0] c, f, m);
    pick = s == 2'h0 ? c : s == 2'h1 ? f - c : s == 2'h2 ? f : m;
  endfunction
  task chk(input [9:0] g, e);
    compares = compares + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task end_of_test;
    $display("bad_count=%0d compares=%0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one-cycle strobes, changed just after the edge
  task wrt(input [7:0] a, d);
    @(posedge clock_in);
    ad <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task rdc(input [7:0] a, e);
    @(posedge clock_in);
    ad <= a;
    rd <= 1'b1;
    @(posedge clock_in);
    rd <= 1'b0;
    #1 chk({2'h0, rdat}, {2'h0, e});
  endtask
  // one random pixel and error sample, then table and pixel outputs
  task px;
    r = {$urandom, $urandom, $urandom};
    @(posedge clock_in);
    er <= r[13:0];
    {lc, lf, ls, cc, cf, cs} <= r[73:14];
    ev <= 1'b1;
    pv <= 1'b1;
    @(posedge clock_in);
    ev <= 1'b0;
    pv <= 1'b0;
    #1 chk({1'b0, tv, tx}, {2'h1, pack(ctl[7:6])});
    // the pixel shows two edges after it was driven and then holds; only its valid stands for one cycle
    @(posedge clock_in);
    #1 chk(lo, pick(ctl[3:2], lc, lf, ls));
    chk(co, pick(ctl[1:0], cc, cf, cs));
    chk({9'h000, pvo}, 10'h001);
  endtask
  // hang guard, well above the expected run length
  always @(posedge clock_in) begin
    cyc = cyc + 1;
    if (cyc > 3000) begin
      bad_count = bad_count + 1;
      end_of_test;
    end
  end
  // all-equal field codes first, then random settings
  initial begin
    i = $urandom(81053);
    repeat (3) @(posedge clock_in);
    rst <= 1'b0;
    rdc(8'h0E, 8'h00);
    for (i = 0; i < 40; i = i + 1) begin
      r = {$urandom, $urandom, $urandom};
      ctl = i < 4 ? 8'h55 * i[7:0] : r[7:0];
      wrt(8'h0E, ctl);
      wrt(8'h10, ~ctl);
      rdc(8'h0E, ctl);
      chk({8'h00, lm}, {8'h00, ctl[5] ? 2'h2 : {1'b0, ctl[4]}});
      chk({9'h000, cm}, {9'h000, ctl[4]});
      px;
      px;
      rdc(8'h10, pack(ctl[7:6]));
      rdc(8'h3C, 8'h00);
    end
    end_of_test;
  end
endmodule
